// File: core/opbz_params.svh
// register map, field positions and reset values of the output port block
`ifndef OPBZ_PARAMS_SVH
`define OPBZ_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define OPBZ_IDX_OUT_DATA  8'h7c
`define OPBZ_IDX_BZ_FREQ   8'hf6
`define OPBZ_IDX_PCLK_DIV  8'hf7

`define OPBZ_ADDR_W        12
`define OPBZ_ADDR_OUT_DATA ({2'h0, `OPBZ_IDX_OUT_DATA, 2'h0})
`define OPBZ_ADDR_BZ_FREQ  ({2'h0, `OPBZ_IDX_BZ_FREQ, 2'h0})
`define OPBZ_ADDR_PCLK_DIV ({2'h0, `OPBZ_IDX_PCLK_DIV, 2'h0})

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define OPBZ_BUZZER_FREQ_SEL_BIT      3
`define OPBZ_DATA_RST      4'h0
`define OPBZ_BUZZER_FREQ_SEL_RST      1'b0
`define OPBZ_PDIV_RST      2'h0

// divider taps: bit n of the free-running counter is fclk/2^(n+1)
`define OPBZ_BZ_TAP_16     3
`define OPBZ_BZ_TAP_32     4
`define OPBZ_DIV_W         8

`endif

// File: core/opbz_pkg.sv
// types shared by the output port block
package opbz_pkg;

  // pin drive of the four output pins; oe_n low while a pin is driven
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe_n;
  } opbz_pins_t;

  // build-time clock-out ratio, in order of the counter tap it selects
  typedef enum logic [2:0] {
    OPBZ_CLOCK_OUT_DIV2,
    OPBZ_CLOCK_OUT_DIV4,
    OPBZ_CLOCK_OUT_DIV8,
    OPBZ_CLOCK_OUT_DIV16,
    OPBZ_CLOCK_OUT_DIV32,
    OPBZ_CLOCK_OUT_DIV64,
    OPBZ_CLOCK_OUT_DIV128,
    OPBZ_CLOCK_OUT_DIV256
  } opbz_clock_out_div_t;

endpackage

// File: core/opbz_port.sv
// four-bit output port with buzzer and clock-out special functions, apb slave
//
// Overview of operation
// [R01] in dc mode each pin follows its data bit; bits read back as written
// [R02] reset clears all four data bits so every pin starts low
// [R03] each bit is fixed at build time as push-pull or p-channel open drain
// [R04] only bits 0, 2 and 3 may take a special function; bit 1 is plain
// [R05] buzzer on pin 0 runs while data bit 0 is 1, otherwise pin low
// [R06] inverse buzzer on pin 3 gated by bit 3 when so optioned
// [R07] with bit-0 control, bit 0 gates both buzzer pins together
// [R08] inverse buzzer on pin 3 needs the buzzer option on pin 0
// [R09] buzzer rate is fclk/32 when select bit is 1, fclk/16 when 0; resets 0
// [R10] buzzer frequency register: only bit 3 stored, low three bits read 0
// [R11] clock-out on pin 2 runs while data bit 2 is 1, otherwise pin low
// [R12] clock-out is fclk divided by a build-time ratio from 2 to 256
// [R13] fclk is the block clock divided by 1, 2, 3 or 4 under software control
// [R14] gating may glitch at on or off; no synchronisation of the gate
// [R15] waves are 50 percent duty from a free-running divider; inverse is exact
`timescale 1ns/1ps
`include "opbz_params.svh"

module opbz_port #(
  parameter logic [3:0]              OPEN_DRAIN  = 4'h0,
  parameter bit                      BZ_EN       = 1'b0,
  parameter bit                      INV_BZ_EN   = 1'b0,
  parameter bit                      INV_CTRL_B0 = 1'b0,
  parameter bit                      CLOCK_OUT_EN     = 1'b0,
  parameter opbz_pkg::opbz_clock_out_div_t CLOCK_OUT_DIV   = opbz_pkg::OPBZ_CLOCK_OUT_DIV16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`OPBZ_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output opbz_pkg::opbz_pins_t         pins
);

  // --------------------------------------------------------------------------
  // option resolution
  // --------------------------------------------------------------------------
  // the inverse buzzer is only honoured when pin 0 carries the buzzer
  localparam bit INV_EFF = INV_BZ_EN && BZ_EN; // see [R08]

  // push-pull bits are always driven; open-drain bits start released
  localparam logic [3:0] OE_N_RST = OPEN_DRAIN;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // one decoder serves both the write and the read path
  function automatic logic [1:0] reg_sel(input logic [`OPBZ_ADDR_W-1:0] a);
    if (a == `OPBZ_ADDR_OUT_DATA)
      reg_sel = 2'h1;
    else if (a == `OPBZ_ADDR_BZ_FREQ)
      reg_sel = 2'h2;
    else if (a == `OPBZ_ADDR_PCLK_DIV)
      reg_sel = 2'h3;
    else
      reg_sel = 2'h0;
  endfunction

  logic [1:0]                sel_c;
  logic                      acc_c;
  logic                      wr_c;
  logic [3:0]                data_q;
  logic                      buzzer_freq_sel_q;
  logic [1:0]                pdiv_q;
  logic [1:0]                pdiv_act_q;
  logic [1:0]                pdiv_cnt_q;
  logic                      pulse_c;
  logic [`OPBZ_DIV_W-1:0]    div_q;
  logic                      bz_c;
  logic                      clock_out_c;
  logic [3:0]                level_c;

  assign sel_c = reg_sel(paddr);
  // access phase with the answer ready: the only edge at which a write lands
  assign acc_c = psel && penable && pready;
  assign wr_c  = acc_c && pwrite && pstrb[0];

  // --------------------------------------------------------------------------
  // apb handshake
  // --------------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // read data and error are loaded together with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= (sel_c == 2'h0);
      prdata  <= 32'h0000_0000;
      if (!pwrite)
      begin
        if (sel_c == 2'h1)
          prdata <= {28'h0, data_q}; // see [R01]
        else if (sel_c == 2'h2)
          prdata <= {28'h0, buzzer_freq_sel_q, 3'h0}; // see [R10]
        else if (sel_c == 2'h3)
          prdata <= {30'h0, pdiv_q};
      end
    end
    else
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // output data; bit 1 is stored like the rest but never leaves dc mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_q <= `OPBZ_DATA_RST; // see [R02]
    else if (wr_c && sel_c == 2'h1)
      data_q <= pwdata[3:0]; // see [R01]
  end

  // buzzer frequency select; low three bits are not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buzzer_freq_sel_q <= `OPBZ_BUZZER_FREQ_SEL_RST; // see [R09]
    else if (wr_c && sel_c == 2'h2)
      buzzer_freq_sel_q <= pwdata[`OPBZ_BUZZER_FREQ_SEL_BIT]; // see [R10]
  end

  // peripheral clock divider select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pdiv_q <= `OPBZ_PDIV_RST;
    else if (wr_c && sel_c == 2'h3)
      pdiv_q <= pwdata[1:0]; // see [R13]
  end

  // --------------------------------------------------------------------------
  // peripheral clock enable
  // --------------------------------------------------------------------------
  // a new ratio is taken only at a pulse, so no period is ever cut short
  assign pulse_c = (pdiv_cnt_q == pdiv_act_q); // see [R13]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdiv_cnt_q <= 2'h0;
      pdiv_act_q <= `OPBZ_PDIV_RST;
    end
    else if (pulse_c)
    begin
      pdiv_cnt_q <= 2'h0;
      pdiv_act_q <= pdiv_q; // see [R13]
    end
    else
      pdiv_cnt_q <= pdiv_cnt_q + 2'h1;
  end

  // --------------------------------------------------------------------------
  // free-running divider and wave taps
  // --------------------------------------------------------------------------
  // never stopped or cleared by the gates, so each tap keeps a 50 percent duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else if (pulse_c)
      div_q <= div_q + `OPBZ_DIV_W'(1); // see [R15]
  end

  // bit n toggles every 2^n pulses, a period of 2^(n+1) fclk
  assign bz_c   = buzzer_freq_sel_q ? div_q[`OPBZ_BZ_TAP_32] : div_q[`OPBZ_BZ_TAP_16]; // see [R09]
  assign clock_out_c = div_q[CLOCK_OUT_DIV]; // see [R12]

  // --------------------------------------------------------------------------
  // pin selection
  // --------------------------------------------------------------------------
  // the gate is a plain and with the data bit; a switch mid-phase may give a
  // short first or last pulse, which the buzzer and clock users tolerate
  always_comb
  begin
    level_c = data_q; // see [R01]
    if (BZ_EN)
      level_c[0] = data_q[0] && bz_c; // see [R05] see [R14]
    // bit 1 has no special source at all
    level_c[1] = data_q[1]; // see [R04]
    if (CLOCK_OUT_EN)
      level_c[2] = data_q[2] && clock_out_c; // see [R11] see [R14]
    if (INV_EFF)
    begin
      if (INV_CTRL_B0)
        level_c[3] = data_q[0] && !bz_c; // see [R07] see [R15]
      else
        level_c[3] = data_q[3] && !bz_c; // see [R06] see [R15]
    end
  end

  // --------------------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------------------
  // open-drain bits only pull high and release for a low level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins.level <= 4'h0; // see [R02]
      pins.oe_n  <= OE_N_RST;
    end
    else
    begin
      pins.level <= level_c;
      pins.oe_n  <= OPEN_DRAIN & ~level_c; // see [R03]
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_gap3;
    (!pulse_c)[*3] ##1 pulse_c;
  endsequence

  sequence s_div3_start;
    pulse_c ##1 (pdiv_act_q == 2'h3);
  endsequence

  logic inv_gate_c;
  assign inv_gate_c = INV_CTRL_B0 ? data_q[0] : data_q[3];

  chk_bit1_plain: assert property ( // see [R04]
    data_q[1] |=> pins.level[1] && !pins.oe_n[1])
    else $error("pin 1 does not follow its data bit");

  chk_zero_data_low: assert property ( // see [R02]
    (data_q == 4'h0) [*2] |-> pins.level == 4'h0)
    else $error("pins not low with all data bits clear");

  chk_drive_type: assert property ( // see [R03]
    ##1 (pins.oe_n == (OPEN_DRAIN & ~pins.level)))
    else $error("output enable does not match drive type");

  chk_bz_off_low: assert property ( // see [R05]
    (BZ_EN && !data_q[0]) |=> !pins.level[0])
    else $error("buzzer pin not low while gated off");

  chk_inv_exact: assert property ( // see [R15]
    (INV_EFF && data_q[0] && inv_gate_c) |=> pins.level[3] == !pins.level[0])
    else $error("inverse buzzer is not the complement");

  chk_inv_off_low: assert property ( // see [R07]
    (INV_EFF && !inv_gate_c) |=> !pins.level[3])
    else $error("inverse buzzer pin not low while gated off");

  chk_bz_rate16: assert property ( // see [R09]
    (pulse_c && !buzzer_freq_sel_q && div_q[2:0] == 3'h7) ##1 !buzzer_freq_sel_q |-> $changed(bz_c))
    else $error("buzzer half period at fclk/16 wrong");

  chk_clock_out_off_low: assert property ( // see [R11]
    (CLOCK_OUT_EN && !data_q[2]) |=> !pins.level[2])
    else $error("clock-out pin not low while gated off");

  chk_pclk_div3: assert property ( // see [R13]
    s_div3_start |-> s_gap3)
    else $error("peripheral clock enable spacing wrong at divide by 4");

  chk_buzzer_freq_sel_read: assert property ( // see [R10]
    (psel && penable && !pready && !pwrite && sel_c == 2'h2)
    |=> pready && prdata[2:0] == 3'h0 && prdata[3] == buzzer_freq_sel_q)
    else $error("frequency register reads wrong");

  // data register paths: one landing edge per transfer, reads one cycle late
  sequence s_rd_data;
    psel && penable && !pready && !pwrite && sel_c == 2'h1;
  endsequence

  chk_data_write: assert property ( // see [R01]
    (acc_c && pwrite && pstrb[0] && sel_c == 2'h1) |=> data_q == $past(pwdata[3:0]))
    else $error("data register write did not land");

  chk_data_read: assert property ( // see [R01]
    s_rd_data |=> pready && prdata == {28'h0, data_q})
    else $error("data register reads wrong");

  chk_strobe_hold: assert property ( // see [R01]
    (acc_c && pwrite && !pstrb[0]) |=> $stable(data_q))
    else $error("write with byte lane 0 off changed data");

  chk_ready_pulse: assert property ( // see [R01]
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  chk_unmapped_err: assert property ( // see [R01]
    (psel && penable && !pready && sel_c == 2'h0) |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  chk_bz_follow: assert property ( // see [R05]
    (BZ_EN && data_q[0]) |=> pins.level[0] == $past(bz_c))
    else $error("buzzer pin does not carry the wave");

  chk_clock_out_follow: assert property ( // see [R11]
    (CLOCK_OUT_EN && data_q[2]) |=> pins.level[2] == $past(clock_out_c))
    else $error("clock-out pin does not carry the clock");

  chk_bz_rate32: assert property ( // see [R09]
    (pulse_c && buzzer_freq_sel_q && div_q[3:0] == 4'hf) ##1 buzzer_freq_sel_q |-> $changed(bz_c))
    else $error("buzzer half period at fclk/32 wrong");

  chk_inv_plain: assert property ( // see [R08]
    (INV_BZ_EN && !BZ_EN) |=> pins.level[3] == $past(data_q[3]))
    else $error("pin 3 not plain without the buzzer option");

  chk_wave_steady: assert property ( // see [R15]
    !pulse_c ##1 $stable(buzzer_freq_sel_q) |-> $stable(bz_c))
    else $error("buzzer wave moved between peripheral clock pulses");

  chk_pclk_div1: assert property ( // see [R13]
    (pdiv_act_q == 2'h0) |-> pulse_c)
    else $error("peripheral clock enable missing at divide by 1");

endmodule

// File: bench/opbz_load.sv
// load model on the four output pins: pull-down and edge timing
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// output pin load
// ----------------------------------------------------------------------------
module opbz_load (
  input  wire logic                 pclk,
  input  wire opbz_pkg::opbz_pins_t pins,
  output logic [3:0]                pad_lvl,
  output logic [3:0][8:0]           half_q
);
  logic [3:0]      prev_q = 4'h0;
  logic [3:0][8:0] cnt_q  = '0;

  // a released p-channel pin is pulled low by the load
  assign pad_lvl = pins.level & ~pins.oe_n;

  // cycles between pad edges give the half period of each wave
  always_ff @(posedge pclk)
  begin
    prev_q <= pad_lvl;
    for (int i = 0; i < 4; i++)
    begin
      cnt_q[i] <= (pad_lvl[i] != prev_q[i]) ? 9'h1 : cnt_q[i] + 9'h1;
      if (pad_lvl[i] != prev_q[i])
        half_q[i] <= cnt_q[i];
    end
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench of the output port block
`timescale 1ns/1ps
`include "opbz_params.svh"

// ----------------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------------
module tb_top;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [`OPBZ_ADDR_W-1:0] paddr = '0;
  logic [31:0]             pwdata = '0;
  logic [3:0]              pstrb = 4'hf;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  opbz_pkg::opbz_pins_t    pins;
  opbz_pkg::opbz_pins_t    pins_b0;
  opbz_pkg::opbz_pins_t    pins_dc;
  logic [3:0]              pad;
  logic [3:0][8:0]         half;
  logic [32:0]             exp_q[$];
  int                      fail_count = 0;
  int                      n_tests = 0;
  logic [31:0]             rnd;

  always #2.5 pclk = ~pclk;

  opbz_port #(.OPEN_DRAIN(4'h2), .BZ_EN(1'b1), .INV_BZ_EN(1'b1), .INV_CTRL_B0(1'b0),
    .CLOCK_OUT_EN(1'b1), .CLOCK_OUT_DIV(opbz_pkg::OPBZ_CLOCK_OUT_DIV4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins));

  opbz_load i_load (.pclk(pclk), .pins(pins), .pad_lvl(pad), .half_q(half));

  // pin 3 gated by data bit 0 together with the buzzer; pin 2 stays plain
  opbz_port #(.OPEN_DRAIN(4'h0), .BZ_EN(1'b1), .INV_BZ_EN(1'b1), .INV_CTRL_B0(1'b1),
    .CLOCK_OUT_EN(1'b0), .CLOCK_OUT_DIV(opbz_pkg::OPBZ_CLOCK_OUT_DIV2)) i_dut_b0 (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(),
    .pslverr(), .pins(pins_b0));

  // inverse buzzer asked for without the buzzer: every pin stays plain
  opbz_port #(.OPEN_DRAIN(4'h0), .BZ_EN(1'b0), .INV_BZ_EN(1'b1), .INV_CTRL_B0(1'b0),
    .CLOCK_OUT_EN(1'b0), .CLOCK_OUT_DIV(opbz_pkg::OPBZ_CLOCK_OUT_DIV2)) i_dut_dc (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(),
    .pslverr(), .pins(pins_dc));

  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (e !== g)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer; a read leaves its expected {pslverr, prdata} in the queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    if (!wr)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // ready is taken at the rising edge that completes the transfer
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // read results are matched against the oldest note
  always @(negedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read", exp_q.pop_front(), {pslverr, prdata});

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    rnd = $urandom(32'h1f989ebc);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OPBZ_ADDR_OUT_DATA, 0, 33'h0);
    apb(1'b0, `OPBZ_ADDR_BZ_FREQ, 0, 33'h0);
    check("pads after reset", 33'h0, {29'h0, pad});
    // random dc data reads back; pin 1 is open drain and never special
    repeat (4)
    begin
      rnd = $urandom;
      apb(1'b1, `OPBZ_ADDR_OUT_DATA, rnd, 0);
      apb(1'b0, `OPBZ_ADDR_OUT_DATA, 0, {29'h0, rnd[3:0]});
      check("pin1", {32'h0, rnd[1]}, {32'h0, pad[1]});
      check("pin1 release", {32'h0, ~rnd[1]}, {32'h0, pins.oe_n[1]});
      check("dc only", {29'h0, rnd[3:0]}, {29'h0, pins_dc.level});
    end
    // a write with byte lane 0 off leaves the data untouched
    pstrb <= 4'he;
    apb(1'b1, `OPBZ_ADDR_OUT_DATA, ~rnd, 0);
    pstrb <= 4'hf;
    apb(1'b0, `OPBZ_ADDR_OUT_DATA, 0, {29'h0, rnd[3:0]});
    apb(1'b1, `OPBZ_ADDR_BZ_FREQ, 32'hffff_ffff, 0);
    apb(1'b0, `OPBZ_ADDR_BZ_FREQ, 0, 33'h8);
    apb(1'b0, 12'h004, 0, {1'b1, 32'h0});
    // buzzer at fclk/32, inverse gated by bit 3, clock-out held off
    apb(1'b1, `OPBZ_ADDR_OUT_DATA, 32'h9, 0);
    repeat (80) @(posedge pclk);
    check("bz half /32", 33'd16, {24'h0, half[0]});
    check("clock_out off", 33'h0, {32'h0, pad[2]});
    check("dc 9", 33'h9, {29'h0, pins_dc.level});
    repeat (20)
    begin
      @(negedge pclk);
      check("inverse bz", {32'h0, ~pad[0]}, {32'h0, pad[3]});
      check("inverse b0", {32'h0, ~pins_b0.level[0]}, {32'h0, pins_b0.level[3]});
    end
    apb(1'b1, `OPBZ_ADDR_BZ_FREQ, 32'h0, 0);
    apb(1'b1, `OPBZ_ADDR_OUT_DATA, 32'h5, 0);
    repeat (60) @(posedge pclk);
    check("bz half /16", 33'd8, {24'h0, half[0]});
    check("clock_out half", 33'd2, {24'h0, half[2]});
    check("inv off", 33'h0, {32'h0, pad[3]});
    check("inv b0 on", {32'h0, ~pins_b0.level[0]}, {32'h0, pins_b0.level[3]});
    check("plain pin2 b0", 33'h1, {32'h0, pins_b0.level[2]});
    check("dc 5", 33'h5, {29'h0, pins_dc.level});
    // peripheral clock at half rate doubles the buzzer half period
    apb(1'b1, `OPBZ_ADDR_PCLK_DIV, 32'h1, 0);
    repeat (80) @(posedge pclk);
    check("bz half div2", 33'd16, {24'h0, half[0]});
    // quarter rate: the divider select reads back and the half period is four times
    apb(1'b1, `OPBZ_ADDR_PCLK_DIV, 32'h3, 0);
    apb(1'b0, `OPBZ_ADDR_PCLK_DIV, 0, 33'h3);
    repeat (160) @(posedge pclk);
    check("bz half div4", 33'd32, {24'h0, half[0]});
    apb(1'b1, `OPBZ_ADDR_OUT_DATA, 32'h8, 0);
    // pins follow the register one edge after the write lands
    repeat (2) @(posedge pclk);
    repeat (40)
    begin
      @(negedge pclk);
      check("bz gated", 33'h0, {32'h0, pad[0]});
      check("b0 gated", 33'h0, {31'h0, pins_b0.level[3], pins_b0.level[0]});
    end
    repeat (4) @(posedge pclk);
    tally_and_finish();
  end
endmodule
